// ===== rtl/ssf_frame_engine.sv
// sync serial frame engine: master and slave frame sequencer
// How it works
// - frames 4..16 bits, msb shifted first
// - high polarity idle: clock high, select high
// - clock pad enabled as master, not slave
// - start: select low, transmit pad enabled
// - first-edge spi: data half period later, clock half after
// - first-edge capture: sample falling, change rising
// - select high one period after last capture
// - first-edge continuous: pulse select between words
// - second-edge: first edge falls, capture rising
// - second-edge continuous: select stays low
// - control word eight bits, no receive
// - control-word idle: clock low, select high
// - load control byte, msb out at select
// - control latched rising, reply latched rising
// - single frame: select up, word to fifo
// - continuous control words follow back to back
// - bit rate is clock/(prescale*(1+rate))
`timescale 1ns/100ps
module ssf_frame_engine import ssf_pkg::*; (
  input  wire logic              mclk_in,
  input  wire logic              rst_in,
  input  wire logic              port_enable_in,
  input  wire logic              slave_mode_in,
  input  wire logic              slave_out_disable_in,
  input  wire logic [7:0]        prescale_divisor_in,
  input  wire ssf_ctrl0_t        control_zero_in,
  input  wire logic              tx_valid_in,
  input  wire logic [DATA_W-1:0] tx_data_in,
  output logic                   tx_pop_out,
  output logic                   rx_valid_out,
  output logic [DATA_W-1:0]      rx_data_out,
  input  wire logic              serial_bit_clock_in,
  input  wire logic              frame_select_in,
  input  wire logic              serial_in,
  output ssf_pins_t              pins_out,
  output logic                   busy_out
);

  ssf_state_t        st_r;
  logic [5:0]        tg_r;
  logic [5:0]        k;
  logic [4:0]        scnt_r;
  logic              first_r;
  logic              sclk_r;
  logic              fss_r;
  logic              sdo_r;
  logic              sdo_oe_r;
  logic              sclk_q_r;
  logic              rx_valid_r;
  logic [DATA_W-1:0] rx_data_r;

  logic              is_cw;
  logic              ph1;
  logic              idle_clk;
  logic [5:0]        two_n;
  logic [5:0]        last_tg;
  logic [5:0]        last_cap;
  logic [5:0]        tail_n;
  logic              hp;
  logic              run;
  logic              xfer_hp;
  logic              start_m;
  logic              m_cap;
  logic              m_sh;
  logic              m_show;
  logic              m_end;
  logic              m_cont;
  logic              m_push;
  logic              lead_show;
  logic              s_act;
  logic              s_start;
  logic              s_rise;
  logic              s_fall;
  logic              cap_rise;
  logic              s_cap;
  logic              s_shf;
  logic              s_last;
  logic              ld;
  logic              show_ld;
  logic [3:0]        ld_size;
  logic [DATA_W-1:0] ld_data;
  logic              ld_msb;
  logic              shift;
  logic              capture;
  logic              sh_msb;
  logic              sh_next;
  logic [DATA_W-1:0] rx_word;
  logic [DATA_W-1:0] rx_next;

  // format decode; the sync format is sequenced as plain spi
  assign is_cw    = control_zero_in.frame_format_select == FRF_CTRLWORD;
  assign ph1      = !is_cw && control_zero_in.clock_phase;
  // control-word idles low, spi idles at its polarity
  assign idle_clk = is_cw ? 1'b0 : control_zero_in.clock_polarity;

  // toggle counts: two per data bit, plus control and wait state
  assign two_n    = {6'(control_zero_in.data_size_select) + 6'h01}
                    << 1;
  assign last_tg  = is_cw ? two_n + CW_OVERHEAD : two_n;
  assign last_cap = is_cw ? last_tg - 6'h01 :
                    ph1   ? two_n : two_n - 6'h01;
  assign tail_n   = ph1 ? TAIL_HALVES_PH1 : TAIL_HALVES_PH0;
  assign k        = tg_r + 6'h01;

  // half-period ticks only while a master frame is in flight
  assign run = (st_r != S_IDLE) && (st_r != S_SLAVE);

  ssf_clk_div u_div (
    .mclk_in       (mclk_in),
    .rst_in        (rst_in),
    .run_in        (run),
    .prescale_in   (prescale_divisor_in),
    .rate_in       (control_zero_in.serial_rate_factor),
    .half_tick_out (hp)
  );

  // master start needs the port on and a queued word
  assign start_m = (st_r == S_IDLE) && port_enable_in &&
                   !slave_mode_in && tx_valid_in;
  assign xfer_hp = (st_r == S_XFER) && hp;

  // capture edges: odd toggles for first-edge, even for second
  always_comb begin
    if (is_cw) begin
      m_cap = xfer_hp && k[0] && (k >= CW_REPLY_FIRST);
      m_sh  = xfer_hp && !k[0] && (k <= CW_LAST_SHIFT);
    end else if (ph1) begin
      m_cap = xfer_hp && !k[0];
      m_sh  = xfer_hp && k[0] && (k != 6'h01);
    end else begin
      m_cap = xfer_hp && k[0];
      m_sh  = xfer_hp && !k[0] && (k != last_tg);
    end
  end

  // second-edge mode drives its first bit on the first toggle
  assign m_show    = xfer_hp && ph1 && (k == 6'h01);
  assign lead_show = (st_r == S_LEAD) && hp && !ph1;
  assign m_end     = xfer_hp && (k == last_tg);
  // back-to-back words only where select may stay low
  assign m_cont    = m_end && (is_cw || ph1) && port_enable_in &&
                     tx_valid_in;
  // control-word reply moves out on the falling edge after it
  assign m_push    = is_cw ? m_end
                           : (m_cap && (k == last_cap));

  // slave side: pins are synchronous, edges seen against last level
  assign s_rise   = serial_bit_clock_in && !sclk_q_r;
  assign s_fall   = !serial_bit_clock_in && sclk_q_r;
  assign cap_rise = is_cw || !(control_zero_in.clock_polarity ^
                               control_zero_in.clock_phase);
  assign s_act    = (st_r == S_SLAVE) && !frame_select_in;
  assign s_start  = (st_r == S_IDLE) && port_enable_in &&
                    slave_mode_in && !frame_select_in;
  assign s_cap    = s_act && (cap_rise ? s_rise : s_fall);
  assign s_shf    = s_act && (cap_rise ? s_fall : s_rise);
  assign s_last   = s_cap &&
                    (scnt_r == 5'(control_zero_in.data_size_select));

  // word loads; an empty queue as slave sends zeros
  assign ld      = start_m || m_cont || s_start || s_last;
  assign ld_size = is_cw ? CTRL_SIZE_SEL
                         : control_zero_in.data_size_select;
  assign ld_data = tx_valid_in ? tx_data_in : 16'h0000;
  assign ld_msb  = ld_data[ld_size];
  assign show_ld = s_start || s_last ||
                   (is_cw && (start_m || m_cont));
  assign tx_pop_out = ld && tx_valid_in;

  assign shift   = m_sh || (s_shf && !first_r);
  assign capture = m_cap || s_cap;

  ssf_shifter u_sh (
    .mclk_in     (mclk_in),
    .rst_in      (rst_in),
    .load_in     (ld),
    .size_in     (ld_size),
    .data_in     (ld_data),
    .shift_in    (shift),
    .capture_in  (capture),
    .bit_in      (serial_in),
    .msb_out     (sh_msb),
    .next_out    (sh_next),
    .rx_word_out (rx_word),
    .rx_next_out (rx_next)
  );

  // sequencer; dropping the enable abandons any frame at once
  always_ff @(posedge mclk_in or posedge rst_in) begin
    if (rst_in) begin
      st_r <= S_IDLE;
    end else if (!port_enable_in) begin
      st_r <= S_IDLE;
    end else begin
      unique case (st_r)
        S_IDLE: begin
          if (start_m) begin
            st_r <= (is_cw || ph1) ? S_XFER : S_LEAD;
          end else if (s_start) begin
            st_r <= S_SLAVE;
          end
        end
        S_LEAD: begin
          if (hp) begin
            st_r <= S_XFER;
          end
        end
        S_SETUP: begin
          if (hp) begin
            st_r <= S_XFER;
          end
        end
        S_XFER: begin
          if (m_end && !m_cont) begin
            st_r <= S_TAIL;
          end
        end
        S_TAIL: begin
          if (hp && (k == tail_n)) begin
            st_r <= S_GAP;
          end
        end
        S_GAP: begin
          if (hp && (k == GAP_HALVES)) begin
            st_r <= S_IDLE;
          end
        end
        S_SLAVE: begin
          if (frame_select_in) begin
            st_r <= S_IDLE;
          end
        end
      endcase
    end
  end

  // half-period counter, reused as toggle count and tail timer
  always_ff @(posedge mclk_in or posedge rst_in) begin
    if (rst_in) begin
      tg_r <= 6'h00;
    end else if (!run || m_end) begin
      tg_r <= 6'h00;
    end else if ((st_r == S_TAIL) && hp && (k == tail_n)) begin
      tg_r <= 6'h00;
    end else if (hp && (st_r != S_LEAD) && (st_r != S_SETUP)) begin
      tg_r <= k;
    end
  end

  // serial clock: idle level outside the transfer, toggles inside
  always_ff @(posedge mclk_in or posedge rst_in) begin
    if (rst_in) begin
      sclk_r <= RST_SCLK;
    end else if (st_r != S_XFER) begin
      sclk_r <= idle_clk;
    end else if (xfer_hp) begin
      sclk_r <= !sclk_r;
    end
  end

  // frame select low from start until the tail has run out
  always_ff @(posedge mclk_in or posedge rst_in) begin
    if (rst_in) begin
      fss_r <= RST_FSS;
    end else if (start_m) begin
      fss_r <= 1'b0;
    end else if ((st_r == S_TAIL) && hp && (k == tail_n)) begin
      fss_r <= 1'b1;
    end else if ((st_r == S_IDLE) || (st_r == S_SLAVE)) begin
      fss_r <= 1'b1;
    end
  end

  // transmit line: msb at load, end of lead or first toggle, next bit on change edges
  always_ff @(posedge mclk_in or posedge rst_in) begin
    if (rst_in) begin
      sdo_r <= RST_SDO;
    end else if (show_ld) begin
      sdo_r <= ld_msb;
    end else if (lead_show || m_show) begin
      sdo_r <= sh_msb;
    end else if (shift) begin
      sdo_r <= sh_next;
    end else if (xfer_hp && is_cw && (k == CW_CTRL_DONE)) begin
      sdo_r <= 1'b0;
    end else if (st_r == S_IDLE) begin
      sdo_r <= 1'b0;
    end
  end

  // transmit pad: master from start until back in idle, through tail and gap, slave per select
  always_ff @(posedge mclk_in or posedge rst_in) begin
    if (rst_in) begin
      sdo_oe_r <= 1'b0;
    end else if (start_m) begin
      sdo_oe_r <= 1'b1;
    end else if (st_r == S_SLAVE) begin
      sdo_oe_r <= !frame_select_in && !slave_out_disable_in;
    end else if (st_r == S_IDLE) begin
      sdo_oe_r <= s_start && !slave_out_disable_in;
    end
  end

  // slave bookkeeping: last clock level, bit count, first-edge skip
  always_ff @(posedge mclk_in or posedge rst_in) begin
    if (rst_in) begin
      sclk_q_r <= 1'b0;
    end else begin
      sclk_q_r <= serial_bit_clock_in;
    end
  end

  // a change edge that comes before any capture after a load keeps the msb on the line
  always_ff @(posedge mclk_in or posedge rst_in) begin
    if (rst_in) begin
      first_r <= 1'b0;
      scnt_r  <= 5'h00;
    end else if (s_start || s_last) begin
      first_r <= 1'b1;
      scnt_r  <= 5'h00;
    end else begin
      if (s_cap || s_shf) begin
        first_r <= 1'b0;
      end
      if (s_cap) begin
        scnt_r <= scnt_r + 5'h01;
      end
    end
  end

  // received word: one-cycle valid, no back-pressure possible here
  always_ff @(posedge mclk_in or posedge rst_in) begin
    if (rst_in) begin
      rx_valid_r <= 1'b0;
      rx_data_r  <= 16'h0000;
    end else begin
      rx_valid_r <= m_push || s_last;
      if (m_push || s_last) begin
        rx_data_r <= capture ? rx_next : rx_word;
      end
    end
  end

  // pads: clock and select are inputs when the port is a slave
  always_comb begin
    pins_out.sclk    = sclk_r;
    pins_out.sclk_oe = !slave_mode_in;
    pins_out.fss     = fss_r;
    pins_out.fss_oe  = !slave_mode_in;
    pins_out.sdo     = sdo_r;
    pins_out.sdo_oe  = sdo_oe_r;
  end

  assign rx_valid_out = rx_valid_r;
  assign rx_data_out  = rx_data_r;
  assign busy_out     = st_r != S_IDLE;

endmodule

// ===== rtl/ssf_pkg.sv
// shared constants and types for the sync serial frame engine
package ssf_pkg;

  // frame data path width and frame format codes
  localparam int unsigned DATA_W       = 16;
  localparam logic [1:0]  FRF_SPI      = 2'h0;
  localparam logic [1:0]  FRF_SYNC     = 2'h1;
  localparam logic [1:0]  FRF_CTRLWORD = 2'h2;

  // control word is always 8 bits: size select holds bits minus one
  localparam logic [3:0]  CTRL_SIZE_SEL = 4'h7;

  // control-word frame toggle numbers of the serial clock
  localparam logic [5:0]  CW_LAST_SHIFT  = 6'h0E;
  localparam logic [5:0]  CW_CTRL_DONE   = 6'h10;
  localparam logic [5:0]  CW_REPLY_FIRST = 6'h13;
  localparam logic [5:0]  CW_OVERHEAD    = 6'h12;

  // half periods after the last toggle before frame select rises, and of the gap after it
  localparam logic [5:0]  TAIL_HALVES_PH0 = 6'h01;
  localparam logic [5:0]  TAIL_HALVES_PH1 = 6'h02;
  localparam logic [5:0]  GAP_HALVES      = 6'h02;

  // pin levels after reset
  localparam logic        RST_FSS  = 1'b1;
  localparam logic        RST_SDO  = 1'b0;
  localparam logic        RST_SCLK = 1'b0;

  // control register zero as one word
  typedef struct packed {
    logic [7:0] serial_rate_factor;
    logic       clock_phase;
    logic       clock_polarity;
    logic [1:0] frame_format_select;
    logic [3:0] data_size_select;
  } ssf_ctrl0_t;

  // serial pad group: value and output enable per pin
  typedef struct packed {
    logic sclk;
    logic sclk_oe;
    logic fss;
    logic fss_oe;
    logic sdo;
    logic sdo_oe;
  } ssf_pins_t;

  typedef enum logic [6:0] {
    S_IDLE  = 7'h01,
    S_LEAD  = 7'h02,
    S_SETUP = 7'h04,
    S_XFER  = 7'h08,
    S_TAIL  = 7'h10,
    S_GAP   = 7'h20,
    S_SLAVE = 7'h40
  } ssf_state_t;

endpackage

// ===== rtl/ssf_clk_div.sv
// half-period tick generator for the serial bit clock
`timescale 1ns/100ps
module ssf_clk_div import ssf_pkg::*; (
  input  wire logic       mclk_in,
  input  wire logic       rst_in,
  input  wire logic       run_in,
  input  wire logic [7:0] prescale_in,
  input  wire logic [7:0] rate_in,
  output logic            half_tick_out
);

  logic [15:0] half_len;
  logic [15:0] cnt_r;
  logic [15:0] cnt_nxt;

  // half period is prescale/2 * (1 + rate); prescale is even
  assign half_len = 16'(prescale_in[7:1]) * (16'(rate_in) + 16'h0001);
  assign cnt_nxt  = cnt_r + 16'h0001;
  // a zero divisor would stall, so treat it as the shortest half
  assign half_tick_out = run_in & (cnt_nxt >= half_len);

  // restart from zero whenever the sequencer is not running
  always_ff @(posedge mclk_in or posedge rst_in) begin
    if (rst_in) begin
      cnt_r <= 16'h0000;
    end else if (!run_in || half_tick_out) begin
      cnt_r <= 16'h0000;
    end else begin
      cnt_r <= cnt_nxt;
    end
  end

endmodule

// ===== rtl/ssf_shifter.sv
// transmit and receive shift registers with variable word size
`timescale 1ns/100ps
module ssf_shifter import ssf_pkg::*; (
  input  wire logic              mclk_in,
  input  wire logic              rst_in,
  input  wire logic              load_in,
  input  wire logic [3:0]        size_in,
  input  wire logic [DATA_W-1:0] data_in,
  input  wire logic              shift_in,
  input  wire logic              capture_in,
  input  wire logic              bit_in,
  output logic                   msb_out,
  output logic                   next_out,
  output logic [DATA_W-1:0]      rx_word_out,
  output logic [DATA_W-1:0]      rx_next_out
);

  logic [DATA_W-1:0] tx_sh_r;
  logic [DATA_W-1:0] rx_sh_r;
  logic [3:0]        size_r;

  // top bit sits at the programmed size, msb first on the line
  assign msb_out     = tx_sh_r[size_r];
  assign next_out    = tx_sh_r[size_r - 4'h1];
  assign rx_word_out = rx_sh_r;
  assign rx_next_out = {rx_sh_r[DATA_W-2:0], bit_in};

  // transmit side
  always_ff @(posedge mclk_in or posedge rst_in) begin
    if (rst_in) begin
      tx_sh_r <= 16'h0000;
      size_r  <= 4'hF;
    end else if (load_in) begin
      tx_sh_r <= data_in;
      size_r  <= size_in;
    end else if (shift_in) begin
      tx_sh_r <= {tx_sh_r[DATA_W-2:0], 1'b0};
    end
  end

  // receive side; cleared on load so unused upper bits read zero
  always_ff @(posedge mclk_in or posedge rst_in) begin
    if (rst_in) begin
      rx_sh_r <= 16'h0000;
    end else if (load_in) begin
      rx_sh_r <= 16'h0000;
    end else if (capture_in) begin
      rx_sh_r <= rx_next_out;
    end
  end

endmodule

// ===== test/ssf_frame_engine_properties.sv
// port-level assertions for the frame engine
`timescale 1ns/100ps
module ssf_frame_engine_properties import ssf_pkg::*; (
  input  wire logic       mclk_in,
  input  wire logic       rst_in,
  input  wire logic       port_enable_in,
  input  wire logic       slave_mode_in,
  input  wire logic       slave_out_disable_in,
  input  wire ssf_ctrl0_t control_zero_in,
  input  wire logic       tx_valid_in,
  input  wire logic       tx_pop_out,
  input  wire logic       rx_valid_out,
  input  wire ssf_pins_t  pins_out,
  input  wire logic       busy_out
);
  default clocking @(posedge mclk_in); endclocking
  default disable iff (rst_in);
  logic [1:0] up_r;
  logic       spi;
  logic       quiet;
  // idle checks wait until pins have left their reset levels
  always_ff @(posedge mclk_in or posedge rst_in) begin
    if (rst_in) up_r <= 2'h0;
    else if (up_r != 2'h3) up_r <= up_r + 2'h1;
  end
  // a settled master idle: idle two edges, config unchanged
  assign spi = control_zero_in.frame_format_select == FRF_SPI;
  assign quiet = up_r == 2'h3 && !busy_out && !slave_mode_in;

  property p_idle_spi;
    quiet && !$past(busy_out) && $stable(control_zero_in) && spi &&
      control_zero_in.clock_polarity |->
      pins_out.sclk && pins_out.fss && !pins_out.sdo;
  endproperty
  a_idle_spi: assert property (p_idle_spi)
    else $error("spi idle pin levels wrong");
  property p_idle_cw;
    quiet && !$past(busy_out) && $stable(control_zero_in) &&
      control_zero_in.frame_format_select == FRF_CTRLWORD |->
      !pins_out.sclk && pins_out.fss && !pins_out.sdo;
  endproperty
  a_idle_cw: assert property (p_idle_cw)
    else $error("control word idle pin levels wrong");
  property p_oe;
    pins_out.sclk_oe == !slave_mode_in && pins_out.fss_oe == !slave_mode_in;
  endproperty
  a_oe: assert property (p_oe)
    else $error("clock pad enable does not follow role");
  property p_no_start;
    !port_enable_in || !tx_valid_in |-> !tx_pop_out;
  endproperty
  a_no_start: assert property (p_no_start)
    else $error("entry taken while disabled or empty");
  property p_start;
    tx_pop_out && !busy_out && !slave_mode_in |=>
      !pins_out.fss && pins_out.sdo_oe;
  endproperty
  a_start: assert property (p_start)
    else $error("frame start without select low and pad on");
  property p_lead;
    $fell(pins_out.fss) && !slave_mode_in && spi &&
      !control_zero_in.clock_phase |-> $stable(pins_out.sclk) [*2];
  endproperty
  a_lead: assert property (p_lead)
    else $error("clock moved before data lead time");
  property p_ph1;
    $fell(pins_out.fss) && !slave_mode_in && spi &&
      control_zero_in.clock_phase && control_zero_in.clock_polarity |->
      pins_out.sclk ##[1:520] $fell(pins_out.sclk);
  endproperty
  a_ph1: assert property (p_ph1)
    else $error("second-edge frame did not open with a falling edge");
  property p_end;
    rx_valid_out && !slave_mode_in && spi && !control_zero_in.clock_phase
      |-> ##[0:8] pins_out.fss;
  endproperty
  a_end: assert property (p_end)
    else $error("select not raised after first-edge word");
  property p_slv_off;
    $past(slave_mode_in) && $past(slave_out_disable_in) &&
      slave_mode_in && slave_out_disable_in |-> !pins_out.sdo_oe;
  endproperty
  a_slv_off: assert property (p_slv_off)
    else $error("slave drove output while disabled");
endmodule

bind ssf_frame_engine ssf_frame_engine_properties u_props (
  .mclk_in(mclk_in), .rst_in(rst_in), .port_enable_in(port_enable_in),
  .slave_mode_in(slave_mode_in),
  .slave_out_disable_in(slave_out_disable_in),
  .control_zero_in(control_zero_in), .tx_valid_in(tx_valid_in),
  .tx_pop_out(tx_pop_out), .rx_valid_out(rx_valid_out),
  .pins_out(pins_out), .busy_out(busy_out));

// ===== test/ssf_slave_model.sv
// off-chip serial slave model facing the master-mode engine
`timescale 1ns/100ps
module ssf_slave_model (
  input  wire logic        sclk_in,
  input  wire logic        fss_in,
  input  wire logic        mosi_in,
  input  wire logic        cw_in,
  input  wire logic        phase_in,
  input  wire logic [4:0]  bits_in,
  input  wire logic [15:0] reply_in,
  output logic             miso_out,
  output logic [15:0]      cap_out
);
  logic [15:0] sh_r;
  logic        drv_r;
  logic        last_r;
  int          k;
  int          c;
  // released line shows the inverse of the last bit, not a stale copy
  assign miso_out = (drv_r && !fss_in) ? sh_r[bits_in-1] : ~last_r;
  initial begin
    cap_out = '0;
    drv_r = 1'b0;
    last_r = 1'b0;
  end
  // select low: restart edge count, present msb at once in spi
  always @(negedge fss_in) begin
    k = 0;
    c = 0;
    sh_r = reply_in;
    drv_r = !cw_in;
  end
  // count clock edges of the frame; role of each edge by format
  always @(sclk_in) begin
    if (fss_in === 1'b0) begin
      k = k + 1;
      if (cw_in) begin
        if (k % 2 == 1 && k <= 15) cap_out = {cap_out[14:0], mosi_in};
        else if (k == 18) drv_r = 1'b1;
        else if (k > 18 && k % 2 == 0) sh_r = sh_r << 1;
        if (k == 18) sh_r = reply_in;
        if (k == 18 + 2 * bits_in) begin
          k = 0;
          drv_r = 1'b0;
        end
      end else if ((k % 2 == 1) == !phase_in) begin
        cap_out = {cap_out[14:0], mosi_in};
      end else begin
        last_r = sh_r[bits_in-1];
        // second-edge words run on without select going high
        if (phase_in && c % bits_in == 0) sh_r = reply_in;
        else sh_r = sh_r << 1;
        c = c + 1;
      end
    end
  end
endmodule

// ===== test/ssf_frame_engine_bench.sv
// self-checking bench for the frame engine
`timescale 1ns/100ps
module ssf_frame_engine_bench import ssf_pkg::*;;
  logic        mclk_in = 1'b0;
  logic        rst_in = 1'b1;
  logic        en = 1'b0;
  logic        slv = 1'b0;
  logic        slv_off = 1'b0;
  ssf_ctrl0_t  ctrl0 = '0;
  logic [15:0] word = '0;
  logic [15:0] reply = '0;
  logic        tb_sclk = 1'b1;
  logic        tb_fss = 1'b1;
  logic        tb_mosi = 1'b0;
  logic [7:0]  psc = 8'h02;
  logic        tx_pop, rx_valid, busy, miso, sclk_w, fss_w, sdo_w;
  logic [15:0] rx_data, got, cap;
  ssf_pins_t   pins;
  int          left = 0, n_rx = 0, rises = 0;
  int          bad_count = 0, n_compared = 0;
  // pad levels: an enabled driver wins, else the bench side for clock and select, the inverted pin value for data
  assign sclk_w = pins.sclk_oe ? pins.sclk : tb_sclk;
  assign fss_w = pins.fss_oe ? pins.fss : tb_fss;
  assign sdo_w = pins.sdo_oe ? pins.sdo : ~pins.sdo;
  ssf_frame_engine uut (.mclk_in(mclk_in), .rst_in(rst_in),
    .port_enable_in(en), .slave_mode_in(slv),
    .slave_out_disable_in(slv_off), .prescale_divisor_in(psc),
    .control_zero_in(ctrl0), .tx_valid_in(left > 0), .tx_data_in(word),
    .tx_pop_out(tx_pop), .rx_valid_out(rx_valid), .rx_data_out(rx_data),
    .serial_bit_clock_in(sclk_w), .frame_select_in(fss_w),
    .serial_in(slv ? tb_mosi : miso), .pins_out(pins), .busy_out(busy));
  ssf_slave_model peer (.sclk_in(sclk_w), .fss_in(fss_w), .mosi_in(sdo_w),
    .cw_in(ctrl0.frame_format_select == FRF_CTRLWORD),
    .phase_in(ctrl0.clock_phase),
    .bits_in({1'b0, ctrl0.data_size_select} + 5'h01),
    .reply_in(reply), .miso_out(miso), .cap_out(cap));
  initial begin
    forever #10 mclk_in = ~mclk_in;
  end
  // transmit queue depth and receive capture
  always @(posedge mclk_in) begin
    if (tx_pop) left <= left - 1;
    if (rx_valid) begin
      got <= rx_data;
      n_rx <= n_rx + 1;
    end
  end
  always @(posedge fss_w) rises = rises + 1;

  task automatic chk(input logic [15:0] g, input logic [15:0] e);
    n_compared++;
    if (g !== e) begin
      bad_count++;
      $display("[ERR] %0t got %h exp %h", $time, g, e);
    end
  endtask
  task automatic final_report;
    $display("compared %0d mismatches %0d", n_compared, bad_count);
    if (bad_count == 0 && n_compared > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask
  // reconfigure only while disabled, enable last
  task automatic cfg(input logic [1:0] f, input logic ph, input logic po,
      input logic [3:0] sz, input logic s);
    @(posedge mclk_in) en <= 1'b0;
    @(posedge mclk_in) slv <= s;
    psc <= (f == FRF_CTRLWORD) ? 8'h04 : 8'h02;
    @(posedge mclk_in) ctrl0 <= '{8'h01, ph, po, f, sz};
    @(posedge mclk_in) en <= 1'b1;
    repeat (4) @(posedge mclk_in);
    rises = 0;
    n_rx <= 0;
  endtask
  task automatic wait_rx(input int cnt);
    int i;
    for (i = 0; i < 3000 && n_rx < cnt; i++) @(posedge mclk_in);
    chk(16'(n_rx), 16'(cnt));
  endtask
  task automatic t_idle;
    cfg(FRF_SPI, 1'b0, 1'b1, 4'h7, 1'b0);
    chk({13'h0, pins.sclk, pins.fss, pins.sdo}, 16'h0006);
    chk({15'h0, busy}, 16'h0000);
    @(posedge mclk_in) en <= 1'b0;
    left <= 1;
    repeat (20) @(posedge mclk_in);
    chk(16'(left), 16'h0001);
    left <= 0;
    cfg(FRF_CTRLWORD, 1'b0, 1'b0, 4'h7, 1'b0);
    chk({13'h0, pins.sclk, pins.fss, pins.sdo}, 16'h0002);
    $display("test idle done");
  endtask
  task automatic t_spi(input logic ph, input logic [3:0] sz,
      input logic [15:0] tx, input logic [15:0] rp, input int cnt);
    logic [15:0] m;
    time t0;
    m = 16'hFFFF >> (4'hF - sz);
    cfg(FRF_SPI, ph, 1'b1, sz, 1'b0);
    reply <= rp;
    word <= tx;
    left <= cnt;
    @(negedge fss_w);
    t0 = $time;
    @(negedge sclk_w);
    chk(16'($time - t0), ph ? 16'h0028 : 16'h0050);
    t0 = $time;
    @(negedge sclk_w);
    chk(16'($time - t0), 16'h0050);
    wait_rx(cnt);
    repeat (12) @(posedge mclk_in);
    chk(got, rp & m);
    chk(cap & m, tx & m);
    chk(16'(rises), ph ? 16'h0001 : 16'(cnt));
    $display("test spi done");
  endtask
  task automatic t_cw(input logic [15:0] rp, input int cnt);
    time t0;
    cfg(FRF_CTRLWORD, 1'b0, 1'b0, 4'hB, 1'b0);
    reply <= rp;
    word <= 16'h3CA5;
    left <= cnt;
    // divisor of four here: one bit period is 160 ns
    @(posedge sclk_w);
    t0 = $time;
    @(posedge sclk_w);
    chk(16'($time - t0), 16'h00A0);
    wait_rx(cnt);
    repeat (20) @(posedge mclk_in);
    chk(got, rp);
    chk(cap & 16'h00FF, 16'h00A5);
    chk(16'(rises), 16'h0001);
    $display("test control word done");
  endtask
  // bench acts as master; engine is a slave with output off
  task automatic t_slave;
    logic [7:0] b;
    int i;
    b = 8'hB4;
    slv_off <= 1'b1;
    cfg(FRF_SPI, 1'b1, 1'b1, 4'h7, 1'b1);
    @(posedge mclk_in) tb_fss <= 1'b0;
    repeat (12) @(posedge mclk_in);
    for (i = 7; i >= 0; i--) begin
      repeat (4) @(posedge mclk_in);
      tb_sclk <= 1'b0;
      tb_mosi <= b[i];
      repeat (4) @(posedge mclk_in);
      tb_sclk <= 1'b1;
    end
    wait_rx(1);
    chk(got, 16'h00B4);
    chk({14'h0, pins.sclk_oe, pins.sdo_oe}, 16'h0000);
    repeat (4) @(posedge mclk_in);
    tb_fss <= 1'b1;
    $display("test slave done");
  endtask
  // a hang is cut short well past the expected run length
  initial begin
    #200us;
    bad_count++;
    final_report;
  end
  initial begin
    repeat (10) @(posedge mclk_in);
    rst_in <= 1'b0;
    @(posedge mclk_in);
    t_idle;
    t_spi(1'b0, 4'hF, 16'hC3A5, 16'h5A3C, 2);
    t_spi(1'b1, 4'h3, 16'h0009, 16'h0006, 3);
    t_spi(1'b0, 4'h3, 16'h000B, 16'h0004, 1);
    t_spi(1'b1, 4'hF, 16'h8001, 16'h7FFE, 1);
    t_cw(16'h0ABC, 2);
    t_cw(16'h0123, 1);
    t_slave;
    final_report;
  end
endmodule
